// ===== verilog/axis_cmd_pkg.sv
package axis_cmd_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int NUM_AXES = 4;
  localparam int DAC_W = 12;
  localparam int TORQ_W = 16;
  localparam int WORD_W = 32;
  localparam int OP_W = 3;
  localparam int ST_W = 3;

  // ------------------------------------------------------------------
  // torque bounds (signed counts of the motor dac)
  // ------------------------------------------------------------------
  localparam logic signed [WORD_W-1:0] TORQUE_LOWER_BOUND = -32'sh000007f8;
  localparam logic signed [WORD_W-1:0] TORQUE_UPPER_BOUND = 32'sh000007f7;

  // ------------------------------------------------------------------
  // command opcodes
  // ------------------------------------------------------------------
  localparam logic [OP_W-1:0] OPEN_LOOP_TORQUE_CMD = 3'h0;
  localparam logic [OP_W-1:0] SETPOINT_WRITE_CMD = 3'h1;
  localparam logic [OP_W-1:0] COMPARE_OUTPUT_DRIVE_CMD = 3'h2;
  localparam logic [OP_W-1:0] RAW_DAC_WRITE_CMD = 3'h3;
  localparam logic [OP_W-1:0] DECEL_RATE_CMD = 3'h4;
  localparam logic [OP_W-1:0] DIRECTION_FLIP_CMD = 3'h5;
  localparam logic [OP_W-1:0] CAPTURE_EDGE_SELECT_CMD = 3'h6;

  // ------------------------------------------------------------------
  // status codes, higher code wins when several axes fail
  // ------------------------------------------------------------------
  localparam logic [ST_W-1:0] ST_OK = 3'h0;
  localparam logic [ST_W-1:0] ST_NOT_ALLOWED = 3'h1;
  localparam logic [ST_W-1:0] ST_WRONG_MODE = 3'h2;
  localparam logic [ST_W-1:0] PARAM_RANGE_ERROR = 3'h3;
  localparam logic [ST_W-1:0] MOTION_OVERRUN_ERROR = 3'h4;
  localparam logic [ST_W-1:0] ST_BAD_OPCODE = 3'h5;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [WORD_W-1:0] DECEL_RESET = 32'h00000000;
  localparam logic signed [TORQ_W-1:0] TORQUE_RESET = 16'sh0000;
  localparam logic signed [DAC_W-1:0] DAC_RESET = 12'sh000;
  localparam logic [WORD_W-1:0] POS_RESET = 32'h00000000;

endpackage : axis_cmd_pkg

// ===== verilog/axis_drive_channel.sv
`timescale 1ns/1ns
`default_nettype none

module axis_drive_channel (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // decoded command for this axis
  input wire logic do_torque,
  input wire logic do_setpoint,
  input wire logic do_raw_dac,
  input wire logic do_decel,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] cmd_word,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] setpoint_value,
  // axis state from surrounding logic
  input wire logic servo_running,
  input wire logic output_enabled_flag,
  input wire logic servo_without_dac_type,
  input wire logic profile_active,
  input wire logic move_active,
  input wire logic signed [axis_cmd_pkg::TORQ_W-1:0] torque_bias,
  input wire logic signed [axis_cmd_pkg::TORQ_W-1:0] law_torque,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] profiler_setpoint,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] speed_mag,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] distance_to_go,
  // results
  output logic [axis_cmd_pkg::ST_W-1:0] cmd_err,
  output logic signed [axis_cmd_pkg::DAC_W-1:0] dac_q,
  output logic [axis_cmd_pkg::WORD_W-1:0] setpoint_q,
  output logic [axis_cmd_pkg::WORD_W-1:0] decel_q,
  output logic stop_req_q
);

  logic signed [axis_cmd_pkg::TORQ_W-1:0] torque_q, torque_d;
  logic signed [axis_cmd_pkg::DAC_W-1:0] dac_d;
  logic [axis_cmd_pkg::WORD_W-1:0] setpoint_d, decel_d;
  logic stop_req_d;
  logic in_range;
  logic [63:0] speed_sq;
  logic [65:0] brake_need;

  function automatic logic signed [axis_cmd_pkg::DAC_W-1:0] clamp(
      input logic signed [axis_cmd_pkg::TORQ_W:0] s);
    if (s > 17'(axis_cmd_pkg::TORQUE_UPPER_BOUND))
      clamp = axis_cmd_pkg::DAC_W'(axis_cmd_pkg::TORQUE_UPPER_BOUND);
    else if (s < 17'(axis_cmd_pkg::TORQUE_LOWER_BOUND))
      clamp = axis_cmd_pkg::DAC_W'(axis_cmd_pkg::TORQUE_LOWER_BOUND);
    else
      clamp = s[axis_cmd_pkg::DAC_W-1:0];
  endfunction : clamp

  // ------------------------------------------------------------------
  // checks and next values
  // ------------------------------------------------------------------
  always_comb begin
    in_range = ($signed(cmd_word) >= axis_cmd_pkg::TORQUE_LOWER_BOUND) &&
               ($signed(cmd_word) <= axis_cmd_pkg::TORQUE_UPPER_BOUND);
    // braking distance at the new decel versus what is left of the move
    speed_sq = {32'h00000000, speed_mag} * {32'h00000000, speed_mag};
    brake_need = ({34'h000000000, cmd_word} * {34'h000000000, distance_to_go}) << 1;
    cmd_err = axis_cmd_pkg::ST_OK;
    torque_d = torque_q;
    setpoint_d = profile_active ? profiler_setpoint : setpoint_q;
    decel_d = decel_q;
    stop_req_d = 1'b0;
    dac_d = dac_q;
    if (do_torque) begin
      if (!in_range) begin
        cmd_err = axis_cmd_pkg::PARAM_RANGE_ERROR;
      end else if (servo_running || !output_enabled_flag) begin
        cmd_err = axis_cmd_pkg::ST_NOT_ALLOWED;
      end else begin
        torque_d = cmd_word[axis_cmd_pkg::TORQ_W-1:0];
      end
    end
    // a direct write wins over the profiler and is not smoothed
    if (do_setpoint) begin
      setpoint_d = setpoint_value;
    end
    if (do_decel) begin
      decel_d = cmd_word;
      if (move_active && (cmd_word < decel_q) && ({2'b00, speed_sq} > brake_need)) begin
        cmd_err = axis_cmd_pkg::MOTION_OVERRUN_ERROR;
        stop_req_d = 1'b1;
      end
    end
    if (servo_without_dac_type) begin
      if (do_raw_dac) begin
        if (!in_range) begin
          cmd_err = axis_cmd_pkg::PARAM_RANGE_ERROR;
        end else begin
          dac_d = cmd_word[axis_cmd_pkg::DAC_W-1:0];
        end
      end
    end else begin
      if (do_raw_dac) begin
        cmd_err = axis_cmd_pkg::ST_WRONG_MODE;
      end
      if (servo_running) begin
        dac_d = clamp(17'(law_torque) + 17'(torque_bias));
      end else if (output_enabled_flag) begin
        dac_d = clamp(17'(torque_d) + 17'(torque_bias));
      end else begin
        dac_d = axis_cmd_pkg::DAC_RESET;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      torque_q <= axis_cmd_pkg::TORQUE_RESET;
      dac_q <= axis_cmd_pkg::DAC_RESET;
      setpoint_q <= axis_cmd_pkg::POS_RESET;
      decel_q <= axis_cmd_pkg::DECEL_RESET;
      stop_req_q <= 1'b0;
    end else begin
      torque_q <= torque_d;
      dac_q <= dac_d;
      setpoint_q <= setpoint_d;
      decel_q <= decel_d;
      stop_req_q <= stop_req_d;
    end
  end

endmodule : axis_drive_channel

`default_nettype wire

// ===== verilog/axis_output_command_unit.sv
`timescale 1ns/1ns
`default_nettype none

module axis_output_command_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // command port
  input wire logic cmd_valid,
  input wire logic [axis_cmd_pkg::OP_W-1:0] cmd_op,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] cmd_axes,
  input wire logic [axis_cmd_pkg::WORD_W-1:0] cmd_word,
  input wire logic cmd_flag,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] cmd_setpoints,
  // command result
  output logic cmd_done_q,
  output logic [axis_cmd_pkg::ST_W-1:0] cmd_status_q,
  // per-axis state from the servo and profiler logic
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] servo_running,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] motor_active_flag,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] output_enabled_flag,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] servo_without_dac_type,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] profile_active,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] move_active,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::TORQ_W-1:0] torque_bias,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::TORQ_W-1:0] law_torque,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] profiler_setpoint,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] speed_mag,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] distance_to_go,
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] encoder_position,
  // capture pins, asynchronous
  input wire logic [axis_cmd_pkg::NUM_AXES-1:0] capture_pin,
  // per-axis outputs
  output logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::DAC_W-1:0] dac_out,
  output logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] servo_setpoint,
  output logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] decel_rate,
  output logic [axis_cmd_pkg::NUM_AXES-1:0] stop_request,
  output logic [axis_cmd_pkg::NUM_AXES-1:0] compare_out_q,
  output logic [axis_cmd_pkg::NUM_AXES-1:0] frame_inverted_q,
  output logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::WORD_W-1:0] frame_position_q,
  output logic [axis_cmd_pkg::NUM_AXES-1:0] capture_rising_q,
  output logic [axis_cmd_pkg::NUM_AXES-1:0] capture_event_q
);

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------
  logic is_torque, is_setpoint, is_compare, is_raw, is_decel, is_flip, is_edge;
  logic [axis_cmd_pkg::NUM_AXES-1:0][axis_cmd_pkg::ST_W-1:0] axis_err;
  logic [axis_cmd_pkg::ST_W-1:0] worst_err;
  logic [axis_cmd_pkg::ST_W-1:0] cmd_status_d;
  logic cmd_done_d;

  always_comb begin
    is_torque = cmd_valid && (cmd_op == axis_cmd_pkg::OPEN_LOOP_TORQUE_CMD);
    is_setpoint = cmd_valid && (cmd_op == axis_cmd_pkg::SETPOINT_WRITE_CMD);
    is_compare = cmd_valid && (cmd_op == axis_cmd_pkg::COMPARE_OUTPUT_DRIVE_CMD);
    is_raw = cmd_valid && (cmd_op == axis_cmd_pkg::RAW_DAC_WRITE_CMD);
    is_decel = cmd_valid && (cmd_op == axis_cmd_pkg::DECEL_RATE_CMD);
    is_flip = cmd_valid && (cmd_op == axis_cmd_pkg::DIRECTION_FLIP_CMD);
    is_edge = cmd_valid && (cmd_op == axis_cmd_pkg::CAPTURE_EDGE_SELECT_CMD);
    // several axes may fail at once; the most severe code is reported
    worst_err = axis_cmd_pkg::ST_OK;
    for (int i = 0; i < axis_cmd_pkg::NUM_AXES; i++) begin
      if (axis_err[i] > worst_err) begin
        worst_err = axis_err[i];
      end
    end
    if (cmd_op > axis_cmd_pkg::CAPTURE_EDGE_SELECT_CMD) begin
      worst_err = axis_cmd_pkg::ST_BAD_OPCODE;
    end
    cmd_done_d = cmd_valid;
    cmd_status_d = cmd_valid ? worst_err : cmd_status_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_done_q <= 1'b0;
      cmd_status_q <= axis_cmd_pkg::ST_OK;
    end else begin
      cmd_done_q <= cmd_done_d;
      cmd_status_q <= cmd_status_d;
    end
  end

  // ------------------------------------------------------------------
  // per-axis logic
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < axis_cmd_pkg::NUM_AXES; g++) begin : g_axis
      logic sel;
      logic compare_d, inverted_d, rising_d, event_d;
      logic [axis_cmd_pkg::WORD_W-1:0] frame_bias_q, frame_bias_d, frame_pos_d, here;
      logic cap_meta_q, cap_sync_q, cap_prev_q;

      assign sel = cmd_axes[g];

      axis_drive_channel u_drive (
        .mclk(mclk),
        .rstn(rstn),
        .do_torque(is_torque && sel),
        .do_setpoint(is_setpoint && sel),
        .do_raw_dac(is_raw && sel),
        .do_decel(is_decel && sel),
        .cmd_word(cmd_word),
        .setpoint_value(cmd_setpoints[g]),
        .servo_running(servo_running[g]),
        .output_enabled_flag(output_enabled_flag[g]),
        .servo_without_dac_type(servo_without_dac_type[g]),
        .profile_active(profile_active[g]),
        .move_active(move_active[g]),
        .torque_bias(torque_bias[g]),
        .law_torque(law_torque[g]),
        .profiler_setpoint(profiler_setpoint[g]),
        .speed_mag(speed_mag[g]),
        .distance_to_go(distance_to_go[g]),
        .cmd_err(axis_err[g]),
        .dac_q(dac_out[g]),
        .setpoint_q(servo_setpoint[g]),
        .decel_q(decel_rate[g]),
        .stop_req_q(stop_request[g])
      );

      always_comb begin
        compare_d = (is_compare && sel) ? cmd_flag : compare_out_q[g];
        rising_d = (is_edge && sel) ? cmd_flag : capture_rising_q[g];
        // reported = bias +/- encoder; a flip keeps the present value fixed
        here = frame_inverted_q[g] ? (frame_bias_q - encoder_position[g])
                                   : (frame_bias_q + encoder_position[g]);
        inverted_d = frame_inverted_q[g];
        frame_bias_d = frame_bias_q;
        if (is_flip && sel && (cmd_flag != frame_inverted_q[g])) begin
          inverted_d = cmd_flag;
          frame_bias_d = (here << 1) - frame_bias_q;
        end
        frame_pos_d = inverted_d ? (frame_bias_d - encoder_position[g])
                                 : (frame_bias_d + encoder_position[g]);
        event_d = capture_rising_q[g] ? (cap_sync_q && !cap_prev_q)
                                      : (!cap_sync_q && cap_prev_q);
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          compare_out_q[g] <= 1'b0;
          capture_rising_q[g] <= 1'b0;
          capture_event_q[g] <= 1'b0;
          frame_inverted_q[g] <= 1'b0;
          frame_bias_q <= axis_cmd_pkg::POS_RESET;
          frame_position_q[g] <= axis_cmd_pkg::POS_RESET;
          cap_meta_q <= 1'b0;
          cap_sync_q <= 1'b0;
          cap_prev_q <= 1'b0;
        end else begin
          compare_out_q[g] <= compare_d;
          capture_rising_q[g] <= rising_d;
          capture_event_q[g] <= event_d;
          frame_inverted_q[g] <= inverted_d;
          frame_bias_q <= frame_bias_d;
          frame_position_q[g] <= frame_pos_d;
          cap_meta_q <= capture_pin[g];
          cap_sync_q <= cap_meta_q;
          cap_prev_q <= cap_sync_q;
        end
      end
    end
  endgenerate

endmodule : axis_output_command_unit

`default_nettype wire

// ===== tb/host_cmd_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------
// host issuing one command at a time
// ------------------------------------------
module host_cmd_model (
  // clock
  input wire logic mclk,
  // command port
  output var logic cmd_valid,
  output var logic [2:0] cmd_op,
  output var logic [3:0] cmd_axes,
  output var logic [31:0] cmd_word,
  output var logic cmd_flag,
  output var logic [3:0][31:0] cmd_setpoints
);
  initial begin
    cmd_valid = 1'b0;
    {cmd_op, cmd_axes, cmd_word, cmd_flag, cmd_setpoints} = '0;
  end
  // word, flag and setpoints are inverted once the strobe drops so stale values never match; op and axes are held
  task automatic send(input logic [2:0] op, input logic [3:0] ax, input logic [31:0] w,
                      input logic f, input logic [3:0][31:0] sp);
    @(negedge mclk);
    cmd_valid = 1'b1;
    {cmd_op, cmd_axes, cmd_word, cmd_flag, cmd_setpoints} = {op, ax, w, f, sp};
    @(negedge mclk);
    cmd_valid = 1'b0;
    {cmd_word, cmd_flag, cmd_setpoints} = {~w, ~f, ~sp};
  endtask : send
endmodule : host_cmd_model
`default_nettype wire

// ===== tb/axis_output_command_unit_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------
// port checker for the command unit
// ------------------------------------------
module axis_output_command_unit_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [3:0] cmd_axes,
  input wire logic [31:0] cmd_word,
  input wire logic cmd_flag,
  input wire logic cmd_done_q,
  input wire logic [2:0] cmd_status_q,
  // axis outputs
  input wire logic [3:0] stop_request,
  input wire logic [3:0] compare_out_q,
  input wire logic [3:0] capture_rising_q,
  input wire logic [3:0] capture_event_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic tq_bad, cmp_cmd, cap_cmd, dec_cmd;
  // signed view so both bounds compare in two's complement
  // a torque command with an empty axis mask reaches no axis and is not refused
  assign tq_bad = cmd_valid && cmd_op == 3'h0 && (|cmd_axes)
    && ($signed(cmd_word) > axis_cmd_pkg::TORQUE_UPPER_BOUND
    || $signed(cmd_word) < axis_cmd_pkg::TORQUE_LOWER_BOUND);
  assign cmp_cmd = cmd_valid && cmd_op == 3'h2;
  assign cap_cmd = cmd_valid && cmd_op == 3'h6;
  assign dec_cmd = cmd_valid && cmd_op == 3'h4;
  a_done_follows_cmd: assert property (cmd_valid |=> cmd_done_q)
    else $error("no done after command");
  a_done_needs_cmd: assert property (!cmd_valid |=> !cmd_done_q)
    else $error("done without command");
  a_status_held: assert property (!cmd_valid |=> $stable(cmd_status_q))
    else $error("status moved without command");
  a_torque_range: assert property (tq_bad |=> cmd_status_q == 3'h3)
    else $error("out of range torque not refused");
  a_compare_level: assert property (cmp_cmd |=> (compare_out_q & $past(cmd_axes))
    == ({4{$past(cmd_flag)}} & $past(cmd_axes)))
    else $error("compare output not at commanded level");
  a_compare_held: assert property (!cmp_cmd |=> $stable(compare_out_q))
    else $error("compare output moved on its own");
  a_edge_select: assert property (cap_cmd |=> (capture_rising_q & $past(cmd_axes))
    == ({4{$past(cmd_flag)}} & $past(cmd_axes)))
    else $error("capture edge select not stored");
  a_overrun_status: assert property (|stop_request |-> cmd_done_q && cmd_status_q == 3'h4)
    else $error("stop without overrun status");
  a_stop_cause: assert property (|stop_request |-> $past(dec_cmd))
    else $error("stop without decel command");
  c_range: cover property (tq_bad ##1 cmd_done_q);
  c_overrun: cover property (|stop_request);
  c_capture: cover property (|capture_event_q);
endmodule : axis_output_command_unit_monitor
bind axis_output_command_unit axis_output_command_unit_monitor mon (.mclk, .rstn,
  .cmd_valid, .cmd_op, .cmd_axes, .cmd_word, .cmd_flag, .cmd_done_q, .cmd_status_q,
  .stop_request, .compare_out_q, .capture_rising_q, .capture_event_q);
`default_nettype wire

// ===== tb/tb_axis_output_command_unit.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_axis_output_command_unit;
  typedef logic [3:0][31:0] w4_t;
  typedef struct packed {
    logic [2:0] op;
    logic [31:0] w;
    logic en, srv, nd;
    logic [2:0] st;
    logic [11:0] dac;
  } row_s;
  // ------------------------------------------
  // design connections
  // ------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_flag, cmd_done_q;
  logic [2:0] cmd_op, cmd_status_q;
  logic [3:0] cmd_axes, servo_running, motor_active_flag, output_enabled_flag, capture_pin;
  logic [3:0] servo_without_dac_type, move_active, stop_request, compare_out_q;
  logic [3:0] frame_inverted_q, capture_rising_q, capture_event_q;
  // profiler idle unless a test drives it, so the setpoint mostly moves on writes
  logic [3:0] profile_active = 4'h0;
  logic [3:0][15:0] torque_bias, law_torque = '0;
  logic [3:0][11:0] dac_out;
  logic [31:0] cmd_word;
  w4_t cmd_setpoints, speed_mag, distance_to_go, encoder_position, servo_setpoint;
  w4_t decel_rate, frame_position_q;
  w4_t profiler_setpoint = '0;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // axis 0 with bias 5: op, word, enabled, servoing, no-dac type, status, dac
  row_s rows [10] = '{
    '{3'h0, 32'h3e8, 1'b1, 1'b0, 1'b0, 3'h0, 12'h3ed},
    '{3'h0, 32'h7f7, 1'b1, 1'b0, 1'b0, 3'h0, 12'h7f7},
    '{3'h0, 32'hfffff808, 1'b1, 1'b0, 1'b0, 3'h0, 12'h80d},
    '{3'h0, 32'h7f8, 1'b1, 1'b0, 1'b0, 3'h3, 12'h80d},
    '{3'h0, 32'hfffff807, 1'b1, 1'b0, 1'b0, 3'h3, 12'h80d},
    '{3'h0, 32'h64, 1'b1, 1'b1, 1'b0, 3'h1, 12'h005},
    '{3'h0, 32'h64, 1'b0, 1'b0, 1'b0, 3'h1, 12'h000},
    '{3'h3, 32'h400, 1'b0, 1'b0, 1'b1, 3'h0, 12'h400},
    '{3'h3, 32'h12c, 1'b0, 1'b0, 1'b0, 3'h2, 12'h000},
    '{3'h7, 32'h0, 1'b1, 1'b0, 1'b0, 3'h5, 12'h80d}
  };
  axis_output_command_unit dut (.*);
  host_cmd_model host (.*);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic cap(input logic f, input logic p, input logic e);
    host.send(3'h6, 4'h1, 32'h0, f, '0);
    capture_pin[0] = p;
    repeat (3) @(negedge mclk);
    `CHK({capture_rising_q[0], capture_event_q[0]}, {f, e})
  endtask : cap
  task automatic dec(input logic [31:0] d, input logic [2:0] s, input logic [3:0] sr);
    host.send(3'h4, 4'h4, d, 1'b0, '0);
    `CHK({cmd_status_q, decel_rate[2], stop_request}, {s, d, sr})
  endtask : dec
  initial begin
    {servo_running, motor_active_flag, output_enabled_flag, capture_pin} = '0;
    servo_without_dac_type = 4'h0;
    move_active = 4'h4;
    torque_bias = {48'h0, 16'h5};
    speed_mag = {32'h0, 32'h3e8, 64'h0};
    distance_to_go = {32'h0, 32'h3e8, 64'h0};
    encoder_position = {64'h0, 32'h64, 32'h0};
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    foreach (rows[i]) begin
      output_enabled_flag[0] = rows[i].en;
      motor_active_flag[0] = rows[i].en;
      servo_running[0] = rows[i].srv;
      servo_without_dac_type[0] = rows[i].nd;
      host.send(rows[i].op, 4'h1, rows[i].w, 1'b0, '0);
      `CHK({cmd_done_q, cmd_status_q, dac_out[0]}, {1'b1, rows[i].st, rows[i].dac})
    end
    rstn = 1'b0;
    @(negedge mclk);
    `CHK({cmd_done_q, cmd_status_q, dac_out, stop_request, decel_rate}, '0)
    rstn = 1'b1;
    host.send(3'h1, 4'hb, 32'h0, 1'b0, {32'h44, 32'h33, 32'h22, 32'h11});
    `CHK(servo_setpoint, {32'h44, 32'h0, 32'h22, 32'h11})
    profile_active[0] = 1'b1;
    profiler_setpoint[0] = 32'h99;
    host.send(3'h1, 4'h1, 32'h0, 1'b0, {96'h0, 32'h55});
    `CHK(servo_setpoint[0], 32'h55)
    @(negedge mclk);
    `CHK(servo_setpoint[0], 32'h99)
    profile_active[0] = 1'b0;
    for (int f = 1; f >= 0; f--) begin
      host.send(3'h2, 4'h5, 32'h0, f[0], '0);
      `CHK(compare_out_q, {2{1'b0, f[0]}})
    end
    `CHK(frame_position_q[1], 32'h64)
    host.send(3'h5, 4'h2, 32'h0, 1'b1, '0);
    encoder_position[1] = 32'h6e;
    repeat (2) @(negedge mclk);
    `CHK({frame_inverted_q[1], frame_position_q[1]}, {1'b1, 32'h5a})
    cap(1'b1, 1'b1, 1'b1);
    cap(1'b1, 1'b0, 1'b0);
    cap(1'b0, 1'b1, 1'b0);
    cap(1'b0, 1'b0, 1'b1);
    dec(32'h3e8, 3'h0, 4'h0);
    dec(32'h258, 3'h0, 4'h0);
    dec(32'h190, 3'h4, 4'h4);
    end_of_test();
  end
endmodule : tb_axis_output_command_unit
`undef CHK
`default_nettype wire
